// >>> verilog/urif_pkg.sv
// Purpose: shared constants and carriers for the uart register interface
// Assumes: 8-bit host bus, three address lines, one system clock
// Notes:   positions and codes are named here and nowhere else

package urif_pkg;

  // ----------------------------------------------------------------
  // register locations
  // ----------------------------------------------------------------
  localparam logic [2:0] LOC_DATA = 3'h0;
  localparam logic [2:0] LOC_IER  = 3'h1;
  localparam logic [2:0] LOC_ISR  = 3'h2;
  localparam logic [2:0] LOC_LCR  = 3'h3;
  localparam logic [2:0] LOC_MCR  = 3'h4;
  localparam logic [2:0] LOC_LSR  = 3'h5;
  localparam logic [2:0] LOC_MSR  = 3'h6;
  localparam logic [2:0] LOC_SPR  = 3'h7;

  // ----------------------------------------------------------------
  // field positions, keys, masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LCR_ENH_KEY   = 8'hBF;
  localparam logic [7:0] REG_RST       = 8'h00;
  localparam logic [7:0] DIV_ZERO      = 8'h00;
  localparam int         LCR_DIV_BIT   = 7;
  localparam int         EFR_ENH_BIT   = 4;
  localparam int         FCR_EN_BIT    = 0;
  localparam int         FCR_RXRST_BIT = 1;
  localparam int         FCR_TXRST_BIT = 2;
  localparam int         FCR_TRIG_LSB  = 6;
  localparam int         IER_RX_BIT    = 0;
  localparam int         IER_TX_BIT    = 1;
  localparam int         IER_LS_BIT    = 2;
  localparam int         IER_MS_BIT    = 3;
  localparam logic [7:0] IER_STD_MASK  = 8'h0F;
  localparam logic [7:0] MCR_STD_MASK  = 8'h1B;
  localparam logic [15:0] BAUD_RELOAD_AT = 16'h0001;

  // ----------------------------------------------------------------
  // interrupt source codes, low six status bits
  // ----------------------------------------------------------------
  localparam logic [5:0] ISR_NONE = 6'h01;
  localparam logic [5:0] ISR_LS   = 6'h06;
  localparam logic [5:0] ISR_RX   = 6'h04;
  localparam logic [5:0] ISR_TX   = 6'h02;
  localparam logic [5:0] ISR_MS   = 6'h00;

  // receive trigger levels selected by the two top control bits
  localparam int RX_TRIG_0 = 1;
  localparam int RX_TRIG_1 = 4;
  localparam int RX_TRIG_2 = 8;
  localparam int RX_TRIG_3 = 14;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RD   = 2'b01,
    BUS_WR   = 2'b10
  } urif_bus_state_t;

  typedef enum logic [4:0] {
    T_DATA, T_DLL, T_DLM, T_REV, T_ID, T_IER, T_ISR_FCR, T_EFR, T_LCR,
    T_MCR, T_XON_CHAR_FIRST, T_XON_CHAR_SECOND, T_LSR, T_MSR, T_XOFF_CHAR_FIRST, T_XOFF_CHAR_SECOND, T_SPR, T_NONE
  } urif_target_t;

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [2:0] addr;
    logic [7:0] data;
  } urif_bus_t;

  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } urif_modem_t;

  typedef struct packed {
    logic       brk;
    logic       fe;
    logic       pe;
    logic [7:0] data;
  } urif_rx_entry_t;

  typedef struct packed {
    logic [7:0] xon_char_first;
    logic [7:0] xon_char_second;
    logic [7:0] xoff_char_first;
    logic [7:0] xoff_char_second;
  } urif_flow_chars_t;

endpackage

// >>> verilog/urif_top.sv
// Purpose: host register interface of a single-channel uart
// Assumes: host strobes and modem pins are asynchronous to clock_i
// Notes:   shifters and flow control sit outside and use the ports below

`timescale 1ns/1ps

module urif_top #(
  parameter int         DEPTH    = 16,
  parameter logic [7:0] REV_CODE = 8'h01,  // arbitrary value
  parameter logic [7:0] ID_CODE  = 8'h5A   // arbitrary value
) (
  // clock and reset
  input  wire logic                       clock_i,
  input  wire logic                       rst_n_i,
  // host bus pins
  input  wire urif_pkg::urif_bus_t        bus_i,
  output logic [7:0]                      data_o,
  output logic                            data_oe_o,
  // modem input pins
  input  wire urif_pkg::urif_modem_t      modem_i,
  // receive shifter side
  input  wire logic                       rx_valid_i,
  input  wire urif_pkg::urif_rx_entry_t   rx_entry_i,
  // transmit shifter side
  input  wire logic                       tx_taken_i,
  input  wire logic                       tx_shift_empty_i,
  output logic                            tx_valid_o,
  output logic [7:0]                      tx_data_o,
  // configuration and events
  output logic                            baud_tick_o,
  output logic [7:0]                      line_ctrl_o,
  output logic [7:0]                      modem_ctrl_o,
  output logic [7:0]                      enh_func_o,
  output urif_pkg::urif_flow_chars_t      flow_chars_o,
  output logic                            irq_o
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  // ----------------------------------------------------------------
  // decode and helpers
  // ----------------------------------------------------------------
  function automatic urif_pkg::urif_target_t decode(input logic [2:0] a,
      input logic [7:0] line_control, input logic div_zero, input logic is_rd);
    urif_pkg::urif_target_t t;
    t = urif_pkg::T_NONE;
    if (line_control == urif_pkg::LCR_ENH_KEY && a == urif_pkg::LOC_ISR) begin
      t = urif_pkg::T_EFR;
    end else if (line_control == urif_pkg::LCR_ENH_KEY && a >= urif_pkg::LOC_MCR) begin
      case (a)
        urif_pkg::LOC_MCR: t = urif_pkg::T_XON_CHAR_FIRST;
        urif_pkg::LOC_LSR: t = urif_pkg::T_XON_CHAR_SECOND;
        urif_pkg::LOC_MSR: t = urif_pkg::T_XOFF_CHAR_FIRST;
        default:           t = urif_pkg::T_XOFF_CHAR_SECOND;
      endcase
    end else begin
      case (a)
        urif_pkg::LOC_DATA: begin
          if (!line_control[urif_pkg::LCR_DIV_BIT])   t = urif_pkg::T_DATA;
          else if (is_rd && div_zero)        t = urif_pkg::T_REV;
          else                               t = urif_pkg::T_DLL;
        end
        urif_pkg::LOC_IER: begin
          if (!line_control[urif_pkg::LCR_DIV_BIT])   t = urif_pkg::T_IER;
          else if (is_rd && div_zero)        t = urif_pkg::T_ID;
          else                               t = urif_pkg::T_DLM;
        end
        urif_pkg::LOC_ISR: t = urif_pkg::T_ISR_FCR;
        urif_pkg::LOC_LCR: t = urif_pkg::T_LCR;
        urif_pkg::LOC_MCR: t = urif_pkg::T_MCR;
        urif_pkg::LOC_LSR: t = urif_pkg::T_LSR;
        urif_pkg::LOC_MSR: t = urif_pkg::T_MSR;
        default:           t = urif_pkg::T_SPR;
      endcase
    end
    return t;
  endfunction

  function automatic logic [CW-1:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0:    return CW'(urif_pkg::RX_TRIG_0);
      2'h1:    return CW'(urif_pkg::RX_TRIG_1);
      2'h2:    return CW'(urif_pkg::RX_TRIG_2);
      default: return CW'(urif_pkg::RX_TRIG_3);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  urif_pkg::urif_bus_t   bus_s1_r, bus_s2_r;
  urif_pkg::urif_modem_t mdm_s1_r, mdm_s2_r, mdm_q_r;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_s1_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 3'h0, data: 8'h00};
      bus_s2_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 3'h0, data: 8'h00};
      mdm_s1_r <= '0;
      mdm_s2_r <= '0;
      mdm_q_r  <= '0;
    end else begin
      bus_s1_r <= bus_i;
      bus_s2_r <= bus_s1_r;
      mdm_s1_r <= modem_i;
      mdm_s2_r <= mdm_s1_r;
      mdm_q_r  <= mdm_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // host access sequencing
  // ----------------------------------------------------------------
  urif_pkg::urif_bus_state_t state_r;
  logic       rd_act, wr_act, rd_start, wr_commit;
  logic [2:0] wr_addr_r;
  logic [7:0] wr_data_r;

  assign rd_act    = !bus_s2_r.cs_n && !bus_s2_r.rd_n;
  assign wr_act    = !bus_s2_r.cs_n && !bus_s2_r.wr_n;
  assign rd_start  = (state_r == urif_pkg::BUS_IDLE) && rd_act;
  assign wr_commit = (state_r == urif_pkg::BUS_WR) && !wr_act;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= urif_pkg::BUS_IDLE;
    end else begin
      case (state_r)
        urif_pkg::BUS_IDLE: begin
          if (rd_act)      state_r <= urif_pkg::BUS_RD;
          else if (wr_act) state_r <= urif_pkg::BUS_WR;
        end
        urif_pkg::BUS_RD: if (!rd_act) state_r <= urif_pkg::BUS_IDLE;
        urif_pkg::BUS_WR: if (!wr_act) state_r <= urif_pkg::BUS_IDLE;
        default:          state_r <= urif_pkg::BUS_IDLE;
      endcase
    end
  end

  // data is taken at the end of the strobe, when it is surely settled
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_addr_r <= 3'h0;
      wr_data_r <= 8'h00;
    end else if (wr_act) begin
      wr_addr_r <= bus_s2_r.addr;
      wr_data_r <= bus_s2_r.data;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] lcr_r, ier_r, efr_r, mcr_r, spr_r, dll_r, dlm_r;
  logic       fifo_en_r;
  logic [1:0] rx_trig_r;
  logic       div_zero;
  urif_pkg::urif_target_t wr_tgt, rd_tgt;

  assign div_zero = (dll_r == urif_pkg::DIV_ZERO) && (dlm_r == urif_pkg::DIV_ZERO);
  assign wr_tgt   = decode(wr_addr_r, lcr_r, div_zero, 1'b0);
  assign rd_tgt   = decode(bus_s2_r.addr, lcr_r, div_zero, 1'b1);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lcr_r        <= urif_pkg::REG_RST;
      ier_r        <= urif_pkg::REG_RST;
      efr_r        <= urif_pkg::REG_RST;
      mcr_r        <= urif_pkg::REG_RST;
      spr_r        <= urif_pkg::REG_RST;
      dll_r        <= urif_pkg::REG_RST;
      dlm_r        <= urif_pkg::REG_RST;
      fifo_en_r    <= 1'b0;
      rx_trig_r    <= 2'h0;
      flow_chars_o <= '0;
    end else if (wr_commit) begin
      case (wr_tgt)
        urif_pkg::T_LCR: lcr_r <= wr_data_r;
        // divisor bytes only behind the divisor enable bit
        urif_pkg::T_DLL: dll_r <= wr_data_r;
        urif_pkg::T_DLM: dlm_r <= wr_data_r;
        // enhanced enable bits need the enhanced-function switch
        urif_pkg::T_IER: ier_r <= efr_r[urif_pkg::EFR_ENH_BIT] ? wr_data_r
                                  : (wr_data_r & urif_pkg::IER_STD_MASK);
        urif_pkg::T_MCR: mcr_r <= efr_r[urif_pkg::EFR_ENH_BIT] ? wr_data_r
                                  : (wr_data_r & urif_pkg::MCR_STD_MASK);
        // dropping the switch retires the enhanced bits
        urif_pkg::T_EFR: begin
          efr_r <= wr_data_r;
          if (!wr_data_r[urif_pkg::EFR_ENH_BIT]) begin
            ier_r <= ier_r & urif_pkg::IER_STD_MASK;
            mcr_r <= mcr_r & urif_pkg::MCR_STD_MASK;
          end
        end
        // other control bits count only with the enable bit set
        urif_pkg::T_ISR_FCR: begin
          fifo_en_r <= wr_data_r[urif_pkg::FCR_EN_BIT];
          if (wr_data_r[urif_pkg::FCR_EN_BIT])
            rx_trig_r <= wr_data_r[urif_pkg::FCR_TRIG_LSB +: 2];
        end
        urif_pkg::T_SPR:   spr_r <= wr_data_r;
        // flow characters in the enhanced map
        urif_pkg::T_XON_CHAR_FIRST:  flow_chars_o.xon_char_first  <= wr_data_r;
        urif_pkg::T_XON_CHAR_SECOND:  flow_chars_o.xon_char_second  <= wr_data_r;
        urif_pkg::T_XOFF_CHAR_FIRST: flow_chars_o.xoff_char_first <= wr_data_r;
        urif_pkg::T_XOFF_CHAR_SECOND: flow_chars_o.xoff_char_second <= wr_data_r;
        default: ;
      endcase
    end
  end

  assign line_ctrl_o  = lcr_r;
  assign modem_ctrl_o = mcr_r;
  assign enh_func_o   = efr_r;

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  logic [15:0] baud_cnt_r;

  // reload from divisor, divisor zero stops the ticks
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      baud_cnt_r  <= 16'h0000;
      baud_tick_o <= 1'b0;
    end else if (div_zero) begin
      baud_cnt_r  <= 16'h0000;
      baud_tick_o <= 1'b0;
    end else if (baud_cnt_r <= urif_pkg::BAUD_RELOAD_AT) begin
      baud_cnt_r  <= {dlm_r, dll_r};
      baud_tick_o <= 1'b1;
    end else begin
      baud_cnt_r  <= baud_cnt_r - 16'h0001;
      baud_tick_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // receive fifo
  // ----------------------------------------------------------------
  urif_pkg::urif_rx_entry_t rx_mem_r [DEPTH];
  urif_pkg::urif_rx_entry_t rx_head;
  logic [PW-1:0] rx_rd_r, rx_wr_r;
  logic [CW-1:0] rx_cnt_r;
  logic [DEPTH-1:0] slot_err;
  logic rx_room, rx_push, rx_pop, rx_flush, rx_err_any, ovr_r;
  logic lsr_rd, msr_rd, isr_rd;

  assign rx_head  = rx_mem_r[rx_rd_r];
  // non-fifo mode holds a single character
  assign rx_room  = fifo_en_r ? (rx_cnt_r < CW'(DEPTH)) : (rx_cnt_r == '0);
  assign rx_push  = rx_valid_i && rx_room;
  // holding read pops the oldest character
  assign rx_pop   = rd_start && (rd_tgt == urif_pkg::T_DATA) && (rx_cnt_r != '0);
  assign rx_flush = wr_commit && (wr_tgt == urif_pkg::T_ISR_FCR)
                    && wr_data_r[urif_pkg::FCR_EN_BIT] && wr_data_r[urif_pkg::FCR_RXRST_BIT];
  assign lsr_rd   = rd_start && (rd_tgt == urif_pkg::T_LSR);
  assign msr_rd   = rd_start && (rd_tgt == urif_pkg::T_MSR);
  assign isr_rd   = rd_start && (rd_tgt == urif_pkg::T_ISR_FCR);

  always_ff @(posedge clock_i) begin
    if (rx_push) rx_mem_r[rx_wr_r] <= rx_entry_i;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_rd_r  <= '0;
      rx_wr_r  <= '0;
      rx_cnt_r <= '0;
    end else if (rx_flush) begin
      rx_rd_r  <= '0;
      rx_wr_r  <= '0;
      rx_cnt_r <= '0;
    end else begin
      if (rx_push) rx_wr_r <= rx_wr_r + PW'(1);
      if (rx_pop)  rx_rd_r <= rx_rd_r + PW'(1);
      if (rx_push && !rx_pop)      rx_cnt_r <= rx_cnt_r + CW'(1);
      else if (rx_pop && !rx_push) rx_cnt_r <= rx_cnt_r - CW'(1);
    end
  end

  // overrun sticky, a new overrun beats the status read
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i)                    ovr_r <= 1'b0;
    else if (rx_valid_i && !rx_room) ovr_r <= 1'b1;
    else if (lsr_rd)                 ovr_r <= 1'b0;
  end

  // error flag over every occupied slot
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    assign slot_err[i] = (CW'(PW'(i) - rx_rd_r) < rx_cnt_r)
                         && (rx_mem_r[i].pe || rx_mem_r[i].fe || rx_mem_r[i].brk);
  end
  assign rx_err_any = |slot_err;

  // ----------------------------------------------------------------
  // transmit fifo and output stage
  // ----------------------------------------------------------------
  logic [7:0]    tx_mem_r [DEPTH];
  logic [PW-1:0] tx_rd_r, tx_wr_r;
  logic [CW-1:0] tx_cnt_r;
  logic tx_push, tx_load, tx_flush, thr_empty, thr_empty_q_r, thre_flag_r;

  // holding write queues one character, dropped when full
  assign tx_push  = wr_commit && (wr_tgt == urif_pkg::T_DATA)
                    && (fifo_en_r ? (tx_cnt_r < CW'(DEPTH))
                                  : ((tx_cnt_r == '0) && !tx_valid_o));
  assign tx_load  = (!tx_valid_o || tx_taken_i) && (tx_cnt_r != '0);
  assign tx_flush = wr_commit && (wr_tgt == urif_pkg::T_ISR_FCR)
                    && wr_data_r[urif_pkg::FCR_EN_BIT] && wr_data_r[urif_pkg::FCR_TXRST_BIT];
  assign thr_empty = (tx_cnt_r == '0) && !tx_valid_o;

  always_ff @(posedge clock_i) begin
    if (tx_push) tx_mem_r[tx_wr_r] <= wr_data_r;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_rd_r    <= '0;
      tx_wr_r    <= '0;
      tx_cnt_r   <= '0;
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
    end else if (tx_flush) begin
      tx_rd_r    <= '0;
      tx_wr_r    <= '0;
      tx_cnt_r   <= '0;
      tx_valid_o <= 1'b0;
    end else begin
      if (tx_push) tx_wr_r <= tx_wr_r + PW'(1);
      if (tx_load) begin
        tx_rd_r   <= tx_rd_r + PW'(1);
        tx_data_o <= tx_mem_r[tx_rd_r];
      end
      if (tx_load || tx_taken_i) tx_valid_o <= tx_load;
      if (tx_push && !tx_load)      tx_cnt_r <= tx_cnt_r + CW'(1);
      else if (tx_load && !tx_push) tx_cnt_r <= tx_cnt_r - CW'(1);
    end
  end

  // ----------------------------------------------------------------
  // status and interrupt sources
  // ----------------------------------------------------------------
  logic [7:0] line_status, irq_status, modem_status;
  logic [3:0] delta_r;
  logic [5:0] isr_code;
  logic ls_pend, rx_pend, tx_pend, ms_pend, ier_tx_on;

  // data ready tracks a non-empty fifo
  assign line_status = {rx_err_any, thr_empty && tx_shift_empty_i, thr_empty,
                (rx_cnt_r != '0) ? {rx_head.brk, rx_head.fe, rx_head.pe} : 3'h0,
                ovr_r, rx_cnt_r != '0};
  assign modem_status = {mdm_s2_r, delta_r};

  // change flags sticky, a new change beats the status read
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) delta_r <= 4'h0;
    else          delta_r <= (msr_rd ? 4'h0 : delta_r) | (mdm_s2_r ^ mdm_q_r);
  end

  assign ier_tx_on = wr_commit && (wr_tgt == urif_pkg::T_IER)
                     && wr_data_r[urif_pkg::IER_TX_BIT] && !ier_r[urif_pkg::IER_TX_BIT];

  // transmit-ready event: empty edge or enabling while empty; set beats clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      thr_empty_q_r <= 1'b1;
      thre_flag_r   <= 1'b0;
    end else begin
      thr_empty_q_r <= thr_empty;
      if ((thr_empty && !thr_empty_q_r) || (ier_tx_on && thr_empty))
        thre_flag_r <= 1'b1;
      else if ((isr_rd && isr_code == urif_pkg::ISR_TX) || tx_push)
        thre_flag_r <= 1'b0;
    end
  end

  // each source gated by its enable bit
  // all four enables clear leaves only polling
  assign ls_pend = ier_r[urif_pkg::IER_LS_BIT] && (|line_status[4:1]);
  // level at or above trigger in fifo mode
  assign rx_pend = ier_r[urif_pkg::IER_RX_BIT]
                   && (fifo_en_r ? (rx_cnt_r >= trig_level(rx_trig_r)) : (rx_cnt_r != '0));
  assign tx_pend = ier_r[urif_pkg::IER_TX_BIT] && thre_flag_r;
  assign ms_pend = ier_r[urif_pkg::IER_MS_BIT] && (|delta_r);

  // status code follows the same level term as the interrupt
  always_comb begin
    if (ls_pend)      isr_code = urif_pkg::ISR_LS;
    else if (rx_pend) isr_code = urif_pkg::ISR_RX;
    else if (tx_pend) isr_code = urif_pkg::ISR_TX;
    else if (ms_pend) isr_code = urif_pkg::ISR_MS;
    else              isr_code = urif_pkg::ISR_NONE;
  end
  // top two bits mirror fifo enable
  assign irq_status = {fifo_en_r, fifo_en_r, isr_code};

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) irq_o <= 1'b0;
    else          irq_o <= ls_pend || rx_pend || tx_pend || ms_pend;
  end

  // ----------------------------------------------------------------
  // read data path
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    case (rd_tgt)
      urif_pkg::T_DATA:    rd_mux = rx_head.data;
      urif_pkg::T_DLL:     rd_mux = dll_r;
      urif_pkg::T_DLM:     rd_mux = dlm_r;
      urif_pkg::T_REV:     rd_mux = REV_CODE;
      urif_pkg::T_ID:      rd_mux = ID_CODE;
      urif_pkg::T_IER:     rd_mux = ier_r;
      urif_pkg::T_ISR_FCR: rd_mux = irq_status;
      urif_pkg::T_EFR:     rd_mux = efr_r;
      urif_pkg::T_LCR:     rd_mux = lcr_r;
      urif_pkg::T_MCR:     rd_mux = mcr_r;
      urif_pkg::T_LSR:     rd_mux = line_status;
      urif_pkg::T_MSR:     rd_mux = modem_status;
      urif_pkg::T_SPR:     rd_mux = spr_r;
      default:             rd_mux = 8'h00;
    endcase
  end

  // value frozen at strobe start so side effects match what the host sees
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o    <= 8'h00;
      data_oe_o <= 1'b0;
    end else begin
      if (rd_start) data_o <= rd_mux;
      data_oe_o <= rd_start || ((state_r == urif_pkg::BUS_RD) && rd_act);
    end
  end

endmodule

// >>> verification/urif_chk.sv
// Purpose: port checks for the uart register block
// Assumes: host holds each strobe six cycles
// Notes:   no transmit fifo reset is issued
`timescale 1ns/1ps
module urif_chk (
  input wire logic                clock_i,
  input wire logic                rst_n_i,
  input wire urif_pkg::urif_bus_t bus_i,
  input wire logic [7:0]          data_o,
  input wire logic                data_oe_o,
  input wire logic                tx_taken_i,
  input wire logic                tx_valid_o,
  input wire logic [7:0]          tx_data_o,
  input wire logic [7:0]          line_ctrl_o,
  input wire logic                irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_rd_cause: assert property ($rose(data_oe_o) |-> !$past(bus_i.cs_n, 3) && !$past(bus_i.rd_n, 3))
    else $error("read data driven without a read strobe");
  a_rd_stable: assert property (data_oe_o && $past(data_oe_o) |-> $stable(data_o))
    else $error("read data moved during a read");
  a_oe_release: assert property ($rose(bus_i.rd_n) |-> ##[1:5] !data_oe_o)
    else $error("data bus held after read strobe");
  a_oe_idle: assert property (bus_i.cs_n [*6] |-> !data_oe_o)
    else $error("data bus driven while unselected");
  a_oe_write: assert property (!bus_i.wr_n [*4] |-> !data_oe_o)
    else $error("data bus driven during a write");
  a_tx_drop: assert property ($fell(tx_valid_o) |-> $past(tx_taken_i))
    else $error("transmit character lost untaken");
  a_tx_hold: assert property (tx_valid_o && !tx_taken_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("transmit character changed untaken");
  a_lcr_write: assert property ($changed(line_ctrl_o) |->
    !$past(bus_i.wr_n, 3) || !$past(bus_i.wr_n, 4) || !$past(bus_i.wr_n, 5))
    else $error("line control changed without a write");
  c_read: cover property ($rose(data_oe_o));
  c_tx: cover property ($fell(tx_valid_o));
  c_irq: cover property ($rose(irq_o));
endmodule
bind urif_top urif_chk u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
  .data_o(data_o), .data_oe_o(data_oe_o), .tx_taken_i(tx_taken_i), .tx_valid_o(tx_valid_o),
  .tx_data_o(tx_data_o), .line_ctrl_o(line_ctrl_o), .irq_o(irq_o));

// >>> verification/urif_host.sv
// Purpose: host processor model on the 8-bit register bus
// Assumes: strobes held six cycles, at least five idle cycles between accesses
// Notes:   released data lines show the inverse of the last byte
`timescale 1ns/1ps
module urif_host (
  input  wire logic           clock_i,
  input  wire logic [7:0]     data_o,
  input  wire logic           data_oe_o,
  output urif_pkg::urif_bus_t bus_o
);
  logic [3:0] ctl_r  = 4'hE;
  logic [2:0] addr_r = 3'h0;
  logic [7:0] dat_r  = 8'h00;
  assign bus_o = {ctl_r[3:1], addr_r, data_oe_o ? data_o : ctl_r[0] ? dat_r : ~dat_r};
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clock_i);
    {ctl_r, addr_r, dat_r} <= {1'b0, w, !w, w, a, d};
    repeat (6) @(posedge clock_i);
    q = bus_o.data;
    ctl_r <= 4'hE;
    repeat (4) @(posedge clock_i);
  endtask
endmodule

// >>> verification/urif_top_test.sv
// Purpose: register level tests of the uart register block
// Assumes: default revision and id parameters
// Notes:   shifters are played by the bench
`timescale 1ns/1ps
module urif_top_test;
  logic                       clock_i  = 1'b0;
  logic                       rst_n_i  = 1'b0;
  urif_pkg::urif_bus_t        bus;
  urif_pkg::urif_modem_t      modem    = 4'h0;
  urif_pkg::urif_rx_entry_t   rx_entry = 11'h000;
  logic                       rx_valid = 1'b0;
  logic                       tx_taken = 1'b0;
  logic                       tx_empty = 1'b1;
  logic [7:0]                 data, q, tx_data, enh, modem_control;
  logic                       data_oe, tx_valid, irq, baud;
  int                         ticks      = 0;
  urif_pkg::urif_flow_chars_t flow;
  int                         num_errors = 0;
  int                         n_tests    = 0;
  initial forever #12.5 clock_i = ~clock_i;
  urif_host u_host (.clock_i(clock_i), .data_o(data), .data_oe_o(data_oe), .bus_o(bus));
  urif_top u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus), .data_o(data),
    .data_oe_o(data_oe), .modem_i(modem), .rx_valid_i(rx_valid), .rx_entry_i(rx_entry),
    .tx_taken_i(tx_taken), .tx_shift_empty_i(tx_empty), .tx_valid_o(tx_valid),
    .tx_data_o(tx_data), .baud_tick_o(baud), .line_ctrl_o(), .modem_ctrl_o(modem_control),
    .enh_func_o(enh),
    .flow_chars_o(flow), .irq_o(irq));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    u_host.acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
    u_host.acc(1'b0, a, 8'h00, q);
    chk(n, q, e);
  endtask
  task automatic push(input logic [10:0] e);
    @(posedge clock_i);
    {rx_valid, rx_entry} <= {1'b1, e};
    @(posedge clock_i);
    rx_valid <= 1'b0;
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    wr(3'h7, 8'hA5);
    rd(3'h7, 8'hA5, "scratchpad");
    wr(3'h3, 8'h80);
    rd(3'h0, 8'h01, "revision");
    rd(3'h1, 8'h5A, "device id");
    wr(3'h0, 8'h03);
    rd(3'h0, 8'h03, "divisor low");
    // divisor three gives one tick every third cycle
    repeat (30) begin
      @(negedge clock_i);
      ticks += baud;
    end
    chk("baud ticks", 8'(ticks), 8'h0A);
    wr(3'h3, 8'h03);
    wr(3'h1, 8'hF0);
    rd(3'h1, 8'h00, "locked ier bits");
    wr(3'h4, 8'hFF);
    chk("locked mcr bits", modem_control, 8'h1B);
    wr(3'h2, 8'h41);
    wr(3'h1, 8'h01);
    push(11'h111);
    push(11'h022);
    push(11'h033);
    rd(3'h2, 8'hC1, "status below trigger");
    push(11'h044);
    repeat (2) @(posedge clock_i);
    chk("irq at trigger", {7'h00, irq}, 8'h01);
    rd(3'h2, 8'hC4, "status at trigger");
    rd(3'h5, 8'hE5, "line status errors");
    rd(3'h0, 8'h11, "oldest char");
    chk("irq below trigger", {7'h00, irq}, 8'h00);
    rd(3'h5, 8'h61, "error flag gone");
    for (int i = 2; i < 5; i++) rd(3'h0, 8'(17 * i), "fifo char");
    rd(3'h5, 8'h60, "fifo empty");
    tx_empty <= 1'b0;
    wr(3'h0, 8'h3C);
    // output stage loads on the edge the write task returns at
    @(posedge clock_i);
    chk("tx char", tx_valid ? tx_data : 8'h00, 8'h3C);
    @(posedge clock_i) tx_taken <= 1'b1;
    @(posedge clock_i) tx_taken <= 1'b0;
    rd(3'h5, 8'h20, "shifter busy");
    tx_empty <= 1'b1;
    modem <= 4'h1;
    repeat (4) @(posedge clock_i);
    rd(3'h6, 8'h11, "modem status");
    wr(3'h1, 8'h00);
    for (int i = 0; i < 17; i++) push(11'h055);
    rd(3'h5, 8'h63, "overrun");
    chk("polled irq", {7'h00, irq}, 8'h00);
    wr(3'h1, 8'h08);
    modem <= 4'h0;
    repeat (4) @(posedge clock_i);
    rd(3'h2, 8'hC0, "modem source");
    rd(3'h6, 8'h01, "modem change");
    chk("modem irq off", {7'h00, irq}, 8'h00);
    wr(3'h3, 8'hBF);
    wr(3'h2, 8'h10);
    chk("enhanced func", enh, 8'h10);
    wr(3'h4, 8'h5D);
    chk("xon first", flow.xon_char_first, 8'h5D);
    rd(3'h4, 8'h00, "write-only xon");
    stop_test;
  end
endmodule
